// ### logic/cpc_map.svh
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

// channel count and minimum shared cycle length in bits
`define CPC_NCH 3
`define CPC_BASE_BITS 8

// word-aligned byte addresses of the global registers
`define CPC_A_CTRL 8'h00
`define CPC_A_CYCLE 8'h04
`define CPC_A_POL 8'h08
`define CPC_A_COUNT 8'h0C
`define CPC_A_PIN 8'h10

// channel n sits at CH0 + n * STRIDE, with these offsets inside it
`define CPC_A_CH0 8'h20
`define CPC_CH_STRIDE 8'h10
`define CPC_O_MODE 8'h00
`define CPC_O_LOW 8'h04
`define CPC_O_HIGH 8'h08

// counter_control_register field positions
`define CPC_CTRL_OVF 6
`define CPC_CTRL_RUN 8

// widths of the register fields
`define CPC_MODE_W 9
`define CPC_CYC_W 2

`endif

// ### logic/cpc_pkg.sv
package cpc_pkg;
`include "cpc_map.svh"

    typedef logic [`CPC_NCH-1:0] cpc_chvec_t;

    // channel_mode_register, bit 0 is event_irq_enable
    typedef struct packed {
        logic toggle_enable;
        logic pwm_enable;
        logic comparator_enable;
        logic falling_capture_enable;
        logic rising_capture_enable;
        logic autoreload_select;
        logic match_flag_enable;
        logic overflow_irq_enable;
        logic event_irq_enable;
    } cpc_mode_t;

    typedef struct packed {
        logic [15:0] count;
        logic run;
        cpc_chvec_t flag;
        logic ovf;
        logic [`CPC_CYC_W-1:0] cycle_sel;
        cpc_chvec_t pol;
        cpc_mode_t [`CPC_NCH-1:0] mode;
        logic [`CPC_NCH-1:0][15:0] capcmp;
        logic [`CPC_NCH-1:0][15:0] reload;
        cpc_chvec_t level;
        cpc_chvec_t pin_out;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } cpc_state_t;

    typedef struct packed {
        cpc_chvec_t s1;
        cpc_chvec_t s2;
        cpc_chvec_t s3;
    } cpc_sync_t;

endpackage : cpc_pkg

// ### logic/cpc_edge_detect.sv
`timescale 1ns/10ps
module cpc_edge_detect (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pin levels
    input wire cpc_pkg::cpc_chvec_t pin_in,
    // synchronised level and edges
    output cpc_pkg::cpc_chvec_t level,
    output cpc_pkg::cpc_chvec_t rise,
    output cpc_pkg::cpc_chvec_t fall
);
    import cpc_pkg::*;

    cpc_sync_t state_ff;
    cpc_sync_t nxt_state;

    // s1 only feeds s2; edges compare s2 with its previous value s3
    always_comb begin
        nxt_state = state_ff;
        nxt_state.s1 = pin_in;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level = state_ff.s2;
    assign rise = state_ff.s2 & ~state_ff.s3;
    assign fall = ~state_ff.s2 & state_ff.s3;

endmodule : cpc_edge_detect

// ### logic/cpc_channel_array.sv
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "cpc_map.svh"
module cpc_channel_array (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // channel pins
    input wire cpc_pkg::cpc_chvec_t channel_io_pin_in,
    output cpc_pkg::cpc_chvec_t channel_io_pin_out,
    output cpc_pkg::cpc_chvec_t channel_io_pin_oe,
    // interrupt request
    output logic counter_array_irq
);
    import cpc_pkg::*;

    localparam int N = `CPC_NCH;

    cpc_state_t state_ff;
    cpc_state_t nxt_state;
    cpc_chvec_t pin_level;
    cpc_chvec_t pin_rise;
    cpc_chvec_t pin_fall;
    cpc_chvec_t cap_evt;
    cpc_chvec_t match_evt;
    logic [15:0] cyc_mask;
    logic ovf_evt;
    logic wr_go;
    cpc_chvec_t ev_en_vec;
    cpc_chvec_t ov_en_vec;

    function automatic logic [7:0] ch_addr(input int n, input logic [7:0] off);
        ch_addr = 8'(`CPC_A_CH0 + n * `CPC_CH_STRIDE + off);
    endfunction : ch_addr

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        be_merge = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                be_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
    endfunction : be_merge

    // shared mask of the 8 to 11 bit cycle, used by overflow and by the pwm match; other matches compare all 16 bits
    function automatic logic [15:0] len_mask(input logic [`CPC_CYC_W-1:0] sel);
        len_mask = 16'((17'h00001 << (`CPC_BASE_BITS + int'(sel))) - 17'h00001);
    endfunction : len_mask

    cpc_edge_detect u_edge (
        .clk(clk),
        .rst(rst),
        .pin_in(channel_io_pin_in),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign cyc_mask = len_mask(state_ff.cycle_sel);
    assign ovf_evt = state_ff.run && ((state_ff.count & cyc_mask) == cyc_mask);
    // one wait cycle per access: the request is accepted on the edge where ack is high
    assign wr_go = write && state_ff.ack;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_evt
            // capture uses the synchronised pin only, never the inverted output
            assign cap_evt[g] = !state_ff.mode[g].pwm_enable && !state_ff.mode[g].toggle_enable &&
                ((pin_rise[g] && state_ff.mode[g].rising_capture_enable) ||
                 (pin_fall[g] && state_ff.mode[g].falling_capture_enable));
            assign match_evt[g] = state_ff.run && state_ff.mode[g].comparator_enable &&
                (state_ff.mode[g].pwm_enable ?
                 (((state_ff.count ^ state_ff.capcmp[g]) & cyc_mask) == 16'h0000) :
                 (state_ff.count == state_ff.capcmp[g]));
        end
    endgenerate

    always_comb begin
        logic [31:0] wm;
        logic [31:0] rv;
        cpc_chvec_t ev_en;
        cpc_chvec_t ov_en;
        wm = '0;
        rv = '0;
        ev_en = '0;
        ov_en = '0;
        nxt_state = state_ff;
        nxt_state.ack = (read || write) && !state_ff.ack;
        if (state_ff.run) begin
            nxt_state.count = state_ff.count + 16'h0001;
        end

        // software writes first, so hardware events below win over clears
        if (wr_go) begin
            unique case (address)
                `CPC_A_CTRL: begin
                    wm = be_merge({23'h000000, state_ff.run, 1'b0, state_ff.ovf, 3'h7, 3'h7}, writedata, byteenable);
                    nxt_state.run = wm[`CPC_CTRL_RUN];
                    nxt_state.ovf = state_ff.ovf && wm[`CPC_CTRL_OVF];
                    nxt_state.flag = state_ff.flag & wm[N-1:0];
                end
                `CPC_A_CYCLE: begin
                    wm = be_merge(32'(state_ff.cycle_sel), writedata, byteenable);
                    nxt_state.cycle_sel = wm[`CPC_CYC_W-1:0];
                end
                `CPC_A_POL: begin
                    wm = be_merge(32'(state_ff.pol), writedata, byteenable);
                    nxt_state.pol = wm[N-1:0];
                end
                default: begin
                end
            endcase
        end

        if (ovf_evt) begin
            nxt_state.ovf = 1'b1;
        end

        for (int n = 0; n < N; n++) begin
            if (wr_go && address == ch_addr(n, `CPC_O_MODE)) begin
                wm = be_merge(32'(state_ff.mode[n]), writedata, byteenable);
                nxt_state.mode[n] = cpc_mode_t'(wm[`CPC_MODE_W-1:0]);
            end
            if (wr_go && byteenable[0] && address == ch_addr(n, `CPC_O_LOW)) begin
                if (state_ff.mode[n].autoreload_select) begin
                    nxt_state.reload[n][7:0] = writedata[7:0];
                end else begin
                    nxt_state.capcmp[n][7:0] = writedata[7:0];
                end
                nxt_state.mode[n].comparator_enable = 1'b0;
            end
            if (wr_go && byteenable[0] && address == ch_addr(n, `CPC_O_HIGH)) begin
                if (state_ff.mode[n].autoreload_select) begin
                    nxt_state.reload[n][15:8] = writedata[7:0];
                end else begin
                    nxt_state.capcmp[n][15:8] = writedata[7:0];
                end
                nxt_state.mode[n].comparator_enable = 1'b1;
            end

            // with autoreload_select set, duty cycle changes only at the cycle boundary to avoid glitches
            if (state_ff.mode[n].pwm_enable && ovf_evt) begin
                nxt_state.capcmp[n] = state_ff.reload[n];
            end
            if (cap_evt[n]) begin
                nxt_state.capcmp[n] = state_ff.count;
                nxt_state.flag[n] = 1'b1;
            end
            if (match_evt[n] && state_ff.mode[n].match_flag_enable) begin
                nxt_state.flag[n] = 1'b1;
            end

            if (state_ff.mode[n].pwm_enable) begin
                if (!nxt_state.mode[n].comparator_enable) begin
                    nxt_state.level[n] = 1'b0;
                end else if (match_evt[n]) begin
                    nxt_state.level[n] = 1'b1;
                end else if (ovf_evt) begin
                    nxt_state.level[n] = 1'b0;
                end
            end else if (state_ff.mode[n].toggle_enable && match_evt[n]) begin
                nxt_state.level[n] = !state_ff.level[n];
            end
            // pin follows the new polarity on the same edge as the write
            nxt_state.pin_out[n] = nxt_state.level[n] ^ nxt_state.pol[n];
            ev_en[n] = nxt_state.mode[n].event_irq_enable;
            ov_en[n] = nxt_state.mode[n].overflow_irq_enable;
        end

        nxt_state.irq = (|(nxt_state.flag & ev_en)) || (nxt_state.ovf && (|ov_en));

        // read data is latched on the first cycle and stands on the accepting edge
        unique case (address)
            `CPC_A_CTRL: rv = 32'({state_ff.run, 1'b0, state_ff.ovf, 3'h0, state_ff.flag});
            `CPC_A_CYCLE: rv = 32'(state_ff.cycle_sel);
            `CPC_A_POL: rv = 32'(state_ff.pol);
            `CPC_A_COUNT: rv = 32'(state_ff.count);
            `CPC_A_PIN: rv = 32'(pin_level);
            default: rv = '0;
        endcase
        for (int n = 0; n < N; n++) begin
            if (address == ch_addr(n, `CPC_O_MODE)) begin
                rv = 32'(state_ff.mode[n]);
            end
            if (address == ch_addr(n, `CPC_O_LOW)) begin
                rv = 32'(state_ff.mode[n].autoreload_select ? state_ff.reload[n][7:0] :
                         state_ff.capcmp[n][7:0]);
            end
            if (address == ch_addr(n, `CPC_O_HIGH)) begin
                rv = 32'(state_ff.mode[n].autoreload_select ? state_ff.reload[n][15:8] :
                         state_ff.capcmp[n][15:8]);
            end
        end
        if (read && !state_ff.ack) begin
            nxt_state.rdata = rv;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign readdata = state_ff.rdata;
    assign waitrequest = (read || write) && !state_ff.ack;
    assign counter_array_irq = state_ff.irq;
    assign channel_io_pin_out = state_ff.pin_out;

    generate
        for (g = 0; g < N; g++) begin : g_oe
            assign channel_io_pin_oe[g] = state_ff.mode[g].pwm_enable || state_ff.mode[g].toggle_enable;
            assign ev_en_vec[g] = state_ff.mode[g].event_irq_enable;
            assign ov_en_vec[g] = state_ff.mode[g].overflow_irq_enable;
        end
    endgenerate

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_pol_at_pin;
        channel_io_pin_out == (state_ff.level ^ state_ff.pol);
    endproperty
    a_pol_at_pin: assert property (p_pol_at_pin)
        else $error("pin output differs from level xor polarity");

    property p_pol_now;
        wr_go && address == `CPC_A_POL && byteenable[0] |=> channel_io_pin_out == ($past(writedata[N-1:0]) ^ state_ff.level);
    endproperty
    a_pol_now: assert property (p_pol_now)
        else $error("polarity write did not reach pins on the next edge");

    property p_reset_pol;
        $fell(rst) |-> state_ff.pol == '0;
    endproperty
    a_reset_pol: assert property (@(posedge clk) p_reset_pol)
        else $error("polarity not cleared by reset");

    property p_ovf_irq;
        $rose(state_ff.ovf) && (|{state_ff.mode[0].overflow_irq_enable, state_ff.mode[1].overflow_irq_enable,
            state_ff.mode[2].overflow_irq_enable}) |-> counter_array_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow did not raise interrupt");

    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("access stalled more than one cycle");

    property p_irq_cause;
        counter_array_irq |-> (|(state_ff.flag & ev_en_vec)) || (state_ff.ovf && (|ov_en_vec));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt raised without an enabled source");

    property p_pin_sync;
        pin_level == $past(channel_io_pin_in, 2);
    endproperty
    a_pin_sync: assert property (p_pin_sync)
        else $error("synchronised pin level not two clocks behind the pin");

    generate
        for (g = 0; g < N; g++) begin : g_chk
            property p_cap_value;
                cap_evt[g] |=> state_ff.capcmp[g] == $past(state_ff.count) && state_ff.flag[g];
            endproperty
            a_cap_value: assert property (p_cap_value)
                else $error("capture did not load counter or set flag");

            property p_cap_beats_clear;
                cap_evt[g] && wr_go && address == `CPC_A_CTRL && byteenable[0] && !writedata[g] |=> state_ff.flag[g];
            endproperty
            a_cap_beats_clear: assert property (p_cap_beats_clear)
                else $error("capture lost against software clear");

            property p_irq_flag;
                state_ff.flag[g] && state_ff.mode[g].event_irq_enable |-> counter_array_irq;
            endproperty
            a_irq_flag: assert property (p_irq_flag)
                else $error("enabled event flag without interrupt");

            property p_comp_off_pwm;
                (state_ff.mode[g].pwm_enable && !state_ff.mode[g].comparator_enable) [*2] |-> !state_ff.level[g];
            endproperty
            a_comp_off_pwm: assert property (p_comp_off_pwm)
                else $error("pwm output not held low with comparator off");

            property p_low_clears;
                wr_go && byteenable[0] && address == ch_addr(g, `CPC_O_LOW) |=>
                    !state_ff.mode[g].comparator_enable;
            endproperty
            a_low_clears: assert property (p_low_clears)
                else $error("low byte write left comparator enabled");

            property p_match_flag;
                match_evt[g] && state_ff.mode[g].match_flag_enable |=> state_ff.flag[g];
            endproperty
            a_match_flag: assert property (p_match_flag)
                else $error("match did not set event flag");

            property p_flag_sticky;
                state_ff.flag[g] && !(wr_go && address == `CPC_A_CTRL) |=> state_ff.flag[g];
            endproperty
            a_flag_sticky: assert property (p_flag_sticky)
                else $error("event flag dropped without software clear");

            property p_cap_trigger;
                !state_ff.mode[g].pwm_enable && !state_ff.mode[g].toggle_enable &&
                    ((state_ff.mode[g].rising_capture_enable && pin_level[g] && !$past(pin_level[g])) ||
                     (state_ff.mode[g].falling_capture_enable && !pin_level[g] && $past(pin_level[g]))) |=>
                    state_ff.flag[g];
            endproperty
            a_cap_trigger: assert property (p_cap_trigger)
                else $error("enabled pin edge did not capture");

            property p_cap_only_edge;
                !$changed(pin_level[g]) |-> !cap_evt[g];
            endproperty
            a_cap_only_edge: assert property (p_cap_only_edge)
                else $error("capture without a pin edge");
        end
    endgenerate

endmodule : cpc_channel_array

// ### verification/cpc_pin_source.sv
`timescale 1ns/10ps
module cpc_pin_source (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level the bench asks the outside source to drive
    input wire cpc_pkg::cpc_chvec_t want,
    // device side of the channel pins
    input wire cpc_pkg::cpc_chvec_t pin_out,
    input wire cpc_pkg::cpc_chvec_t pin_oe,
    output cpc_pkg::cpc_chvec_t pin_in
);
    import cpc_pkg::*;
    cpc_chvec_t src_ff;
    int held_ff;
    // a new level is taken only once the old one has stood two clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_ff <= '0;
            held_ff <= 0;
        end else if (want != src_ff && held_ff >= 2) begin
            src_ff <= want;
            held_ff <= 1;
        end else if (held_ff < 2) begin
            held_ff <= held_ff + 1;
        end
    end
    // the source lets go of a pin while the device drives it
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_ff);
endmodule : cpc_pin_source

// ### verification/cpc_channel_array_tb.sv
`timescale 1ns/10ps
`include "cpc_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpc_channel_array_tb;
    import cpc_pkg::*;
    logic clk;
    logic rst;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    cpc_chvec_t pin_in;
    cpc_chvec_t pin_out;
    cpc_chvec_t pin_oe;
    cpc_chvec_t want;
    logic irq;
    int fail_count;
    int comparisons;
    logic [31:0] q;
    logic [31:0] lo;
    logic [15:0] cnt;
    logic [7:0] base;
    logic [7:0] b[4];
    int ch;
    int cyc;
    int bad;
    int seen;
    int ie;
    int m_flag;

    cpc_channel_array i_dut (
        .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .channel_io_pin_in(pin_in),
        .channel_io_pin_out(pin_out), .channel_io_pin_oe(pin_oe), .counter_array_irq(irq)
    );
    cpc_pin_source i_src (
        .clk(clk), .rst(rst), .want(want), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
    );

    task automatic end_sim();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // one avalon access; the request stands until waitrequest is seen low
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 64);
        if (n >= 64) begin
            fail_count++;
            end_sim();
        end
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #(40 * 60000);
        fail_count++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        want = '0;
        fail_count = 0;
        comparisons = 0;
        void'($urandom(3148));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(pin_out, 3'h0)
        bus(`CPC_A_POL, 0, 0);
        `CHK(q[2:0], 3'h0)
        bus(8'hFC, 0, 0);
        `CHK(q, 32'h0)
        bus(`CPC_A_COUNT, 1, 32'h1234);
        bus(`CPC_A_COUNT, 0, 0);
        `CHK(q[15:0], 16'h0)
        repeat (4) begin
            bus(`CPC_A_POL, 1, 32'($urandom_range(7)));
            lo = writedata;
            @(posedge clk);
            #1;
            `CHK(pin_out, lo[2:0])
        end
        // freeze the counter at a random value so captures are exact
        bus(`CPC_A_CTRL, 1, 32'h100);
        repeat ($urandom_range(300, 20)) @(posedge clk);
        bus(`CPC_A_CTRL, 1, 32'h0);
        bus(`CPC_A_COUNT, 0, 0);
        cnt = q[15:0];
        bus(`CPC_A_POL, 1, 32'h7);
        for (ch = 0; ch < 3; ch++) begin
            base = 8'(`CPC_A_CH0 + ch * `CPC_CH_STRIDE);
            for (int em = 1; em < 4; em++) begin
                ie = $urandom_range(1);
                bus(base + `CPC_O_MODE, 1, 32'((em << 4) | ie));
                for (int dir = 1; dir >= 0; dir--) begin
                    want <= cpc_chvec_t'(dir << ch);
                    repeat (8) @(posedge clk);
                    m_flag = dir ? em & 1 : em >> 1;
                    bus(`CPC_A_CTRL, 0, 0);
                    `CHK(q[2:0], 3'(m_flag << ch))
                    `CHK(irq, 1'(m_flag & ie))
                    bus(`CPC_A_PIN, 0, 0);
                    `CHK(q[2:0], 3'(dir << ch))
                    if (m_flag) begin
                        bus(base + `CPC_O_LOW, 0, 0);
                        lo = q;
                        bus(base + `CPC_O_HIGH, 0, 0);
                        `CHK({q[7:0], lo[7:0]}, cnt)
                        bus(`CPC_A_CTRL, 0, 0);
                        `CHK(q[2:0], 3'(1 << ch))
                    end
                    bus(`CPC_A_CTRL, 1, 0);
                    bus(`CPC_A_CTRL, 0, 0);
                    `CHK(q[2:0], 3'h0)
                end
            end
        end
        // pin edge timed so the capture lands on the same edge as the flag clear
        want <= 3'h4;
        @(posedge clk);
        bus(`CPC_A_CTRL, 1, 0);
        bus(`CPC_A_CTRL, 0, 0);
        `CHK(q[2:0], 3'h4)
        bus(`CPC_A_CTRL, 1, 0);
        ch = $urandom_range(2);
        base = 8'(`CPC_A_CH0 + ch * `CPC_CH_STRIDE);
        foreach (b[i]) b[i] = 8'($urandom);
        bus(base + `CPC_O_MODE, 1, 32'h40);
        bus(base + `CPC_O_LOW, 1, 32'(b[0]));
        bus(base + `CPC_O_MODE, 0, 0);
        `CHK(q[6], 1'b0)
        bus(base + `CPC_O_HIGH, 1, 32'(b[1]));
        bus(base + `CPC_O_MODE, 0, 0);
        `CHK(q[6], 1'b1)
        bus(base + `CPC_O_MODE, 1, 32'h8);
        bus(base + `CPC_O_LOW, 1, 32'(b[2]));
        bus(base + `CPC_O_HIGH, 1, 32'(b[3]));
        for (int s = 0; s < 2; s++) begin
            bus(base + `CPC_O_MODE, 1, 32'(s << 3));
            bus(base + `CPC_O_LOW, 0, 0);
            lo = q;
            bus(base + `CPC_O_HIGH, 0, 0);
            `CHK({q[7:0], lo[7:0]}, s ? {b[3], b[2]} : {b[1], b[0]})
        end
        // pwm with the comparator off must stay low for two whole cycles
        bus(`CPC_A_POL, 1, 0);
        cyc = $urandom_range(3);
        bus(`CPC_A_CYCLE, 1, 32'(cyc));
        bus(base + `CPC_O_MODE, 1, 32'h84);
        bus(`CPC_A_CTRL, 1, 32'h100);
        bad = 0;
        repeat (2 << (8 + cyc)) begin
            @(posedge clk);
            bad += pin_out[ch];
        end
        `CHK(bad, 0)
        `CHK(pin_oe[ch], 1'b1)
        bus(`CPC_A_CTRL, 0, 0);
        `CHK(q[ch], 1'b0)
        `CHK(q[6], 1'b1)
        `CHK(irq, 1'b0)
        bus(base + `CPC_O_MODE, 1, 32'h86);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        bus(base + `CPC_O_LOW, 1, 32'h40);
        bus(base + `CPC_O_HIGH, 1, 32'h0);
        seen = 0;
        repeat (2 << (8 + cyc)) begin
            @(posedge clk);
            seen |= pin_out[ch];
        end
        `CHK(seen, 1)
        bus(`CPC_A_CTRL, 0, 0);
        `CHK(q[ch], 1'b1)
        // toggle mode: the pin holds with the comparator off and toggles once it is back on
        bus(base + `CPC_O_MODE, 1, 32'h104);
        bus(`CPC_A_CTRL, 1, 32'h100);
        seen = pin_out[ch];
        bus(`CPC_A_COUNT, 0, 0);
        cnt = q[15:0] + 16'h0028;
        bus(base + `CPC_O_LOW, 1, 32'(cnt[7:0]));
        repeat (64) @(posedge clk);
        `CHK(pin_out[ch], 1'(seen))
        bus(`CPC_A_COUNT, 0, 0);
        cnt = q[15:0] + 16'h0028;
        bus(base + `CPC_O_LOW, 1, 32'(cnt[7:0]));
        bus(base + `CPC_O_HIGH, 1, 32'(cnt[15:8]));
        repeat (64) @(posedge clk);
        `CHK(pin_out[ch], 1'(~seen))
        bus(`CPC_A_CTRL, 0, 0);
        `CHK(q[ch], 1'b1)
        bus(`CPC_A_CTRL, 1, 0);
        end_sim();
    end
endmodule : cpc_channel_array_tb
